// ==== cir_unit.sv ====
// Purpose: interrupt response unit of an 8-bit processor core
// Assumes: core pulses arrive on clock; pins are asynchronous and are synchronised
// Notes: one clock cycle per T state; data bus sampled through a two-stage sync
`timescale 1ns/1ps
`include "cir_map.svh"

module cir_unit (
    input wire logic clock,
    input wire logic rstn,
    input wire logic nmi_pin,
    input wire logic int_pin,
    input wire logic bus_request_in,
    input wire logic [7:0] data_bus_pin,
    input wire logic instr_boundary,
    input wire logic disable_int_instr,
    input wire logic enable_int_instr,
    input wire logic return_from_nonmask_instr,
    input wire logic set_mode_instr,
    input wire logic [1:0] set_mode_value,
    input wire logic write_vector_page,
    input wire logic write_refresh,
    input wire logic [7:0] write_data,
    input wire logic read_vector_page,
    input wire logic read_refresh,
    input wire logic fetch_refresh,
    input wire logic [15:0] pc_in,
    output logic opcode_fetch_cycle,
    output logic io_request_strobe,
    output logic memory_request_strobe,
    output logic [15:0] addr_out,
    output logic service_valid,
    output logic [15:0] service_addr,
    output logic jam_valid,
    output logic [7:0] jam_opcode,
    output logic int_enable_ff_one,
    output logic int_enable_ff_two,
    output logic [1:0] int_mode_flops,
    output logic [7:0] vector_page,
    output logic [7:0] refresh_count,
    output logic pv_flag,
    output logic pv_valid,
    output logic ack_busy
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers; first stages feed only the second stages

    logic nmi_meta_reg, nmi_sync_reg, nmi_last_reg;
    logic int_meta_reg, int_sync_reg;
    logic bus_request_in_meta_reg, bus_request_in_sync_reg;
    logic [7:0] data_meta_reg, data_sync_reg;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            nmi_meta_reg <= 1'b0;
            nmi_sync_reg <= 1'b0;
            nmi_last_reg <= 1'b0;
            int_meta_reg <= 1'b0;
            int_sync_reg <= 1'b0;
            bus_request_in_meta_reg <= 1'b0;
            bus_request_in_sync_reg <= 1'b0;
            data_meta_reg <= 8'h00;
            data_sync_reg <= 8'h00;
        end
        else
        begin
            nmi_meta_reg <= nmi_pin;
            nmi_sync_reg <= nmi_meta_reg;
            nmi_last_reg <= nmi_sync_reg;
            int_meta_reg <= int_pin;
            int_sync_reg <= int_meta_reg;
            bus_request_in_meta_reg <= bus_request_in;
            bus_request_in_sync_reg <= bus_request_in_meta_reg;
            data_meta_reg <= data_bus_pin;
            data_sync_reg <= data_meta_reg;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// response state

    cir_pkg::cir_state_t state_reg, state_next;
    logic iff1_reg, iff1_next, iff2_reg, iff2_next;
    logic [1:0] mode_reg, mode_next;
    logic [7:0] page_reg, page_next, refresh_reg, refresh_next;
    logic nmi_pend_reg, nmi_pend_next;
    logic ofc_reg, ofc_next, io_reg, io_next, memory_request_strobe_reg, memory_request_strobe_next;
    logic [15:0] addr_reg, addr_next, svc_addr_reg, svc_addr_next;
    logic svc_reg, svc_next, jam_reg, jam_next;
    logic [7:0] jam_op_reg, jam_op_next, lo_reg, lo_next;
    logic pv_reg, pv_next, pv_valid_reg, pv_valid_next;
    logic hi_sel_reg, hi_sel_next, busy_reg, busy_next;
    logic [1:0] cnt_reg, cnt_next;

    always_comb
    begin
        state_next = state_reg;
        iff1_next = iff1_reg;
        iff2_next = iff2_reg;
        mode_next = mode_reg;
        page_next = page_reg;
        refresh_next = refresh_reg;
        nmi_pend_next = nmi_pend_reg;
        ofc_next = ofc_reg;
        io_next = io_reg;
        memory_request_strobe_next = memory_request_strobe_reg;
        addr_next = addr_reg;
        svc_addr_next = svc_addr_reg;
        svc_next = 1'b0;
        jam_next = 1'b0;
        jam_op_next = jam_op_reg;
        lo_next = lo_reg;
        pv_next = pv_reg;
        pv_valid_next = 1'b0;
        hi_sel_next = hi_sel_reg;
        cnt_next = cnt_reg;

        // core instruction effects; enable wins if both pulse together
        if (disable_int_instr)
        begin
            iff1_next = 1'b0;
            iff2_next = 1'b0;
        end
        if (enable_int_instr)
        begin
            iff1_next = 1'b1;
            iff2_next = 1'b1;
        end
        if (return_from_nonmask_instr)
            iff1_next = iff2_reg;
        // code 3 names no mode and is ignored
        if (set_mode_instr && set_mode_value != 2'h3)
            mode_next = set_mode_value;
        if (write_vector_page)
            page_next = write_data;
        if (read_vector_page || read_refresh)
        begin
            pv_next = iff2_reg;
            pv_valid_next = 1'b1;
        end
        if (write_refresh)
            refresh_next = write_data;
        else if (fetch_refresh && state_reg == cir_pkg::CIR_IDLE)
        begin
            addr_next = {page_reg, refresh_reg};
            refresh_next = refresh_reg + 8'h01;
        end

        unique case (state_reg)
            cir_pkg::CIR_IDLE:
            begin
                if (instr_boundary && !bus_request_in_sync_reg)
                begin
                    if (nmi_pend_reg)
                    begin
                        // non-maskable first, and it keeps the second flip-flop
                        nmi_pend_next = 1'b0;
                        iff1_next = 1'b0;
                        svc_addr_next = `CIR_NMI_ADDR;
                        svc_next = 1'b1;
                    end
                    else if (int_sync_reg && iff1_reg)
                    begin
                        iff1_next = 1'b0;
                        iff2_next = 1'b0;
                        ofc_next = 1'b1;
                        addr_next = pc_in;
                        state_next = cir_pkg::CIR_T1;
                    end
                end
            end
            cir_pkg::CIR_T1:
                state_next = cir_pkg::CIR_T2;
            cir_pkg::CIR_T2:
            begin
                io_next = 1'b1;
                state_next = cir_pkg::CIR_W1;
            end
            cir_pkg::CIR_W1:
                state_next = cir_pkg::CIR_W2;
            cir_pkg::CIR_W2:
            begin
                addr_next = {page_reg, refresh_reg};
                refresh_next = refresh_reg + 8'h01;
                state_next = cir_pkg::CIR_T3;
            end
            cir_pkg::CIR_T3:
            begin
                ofc_next = 1'b0;
                io_next = 1'b0;
                state_next = cir_pkg::CIR_IDLE;
                hi_sel_next = 1'b0;
                cnt_next = 2'h0;
                if (mode_reg == cir_pkg::CIR_MODE1)
                begin
                    svc_addr_next = `CIR_MODE1_ADDR;
                    svc_next = 1'b1;
                end
                else if (mode_reg == cir_pkg::CIR_MODE2)
                begin
                    // bit zero is trusted clear from the peripheral
                    addr_next = {page_reg, data_sync_reg};
                    memory_request_strobe_next = 1'b1;
                    state_next = cir_pkg::CIR_RD;
                end
                else if (data_sync_reg == `CIR_CALL_OPCODE)
                begin
                    addr_next = pc_in;
                    memory_request_strobe_next = 1'b1;
                    state_next = cir_pkg::CIR_RD;
                end
                else if ((data_sync_reg & `CIR_RST_MASK) == `CIR_RST_MATCH)
                begin
                    svc_addr_next = {10'h000,
                        data_sync_reg[`CIR_RST_MSB:`CIR_RST_LSB], 3'h0};
                    svc_next = 1'b1;
                end
                else
                begin
                    // any other jammed instruction goes to the core to run
                    jam_op_next = data_sync_reg;
                    jam_next = 1'b1;
                end
            end
            cir_pkg::CIR_RD:
            begin
                cnt_next = cnt_reg + 2'h1;
                if (cnt_reg == `CIR_READ_CYCLES - 2'h1)
                begin
                    cnt_next = 2'h0;
                    if (!hi_sel_reg)
                    begin
                        lo_next = data_sync_reg;
                        hi_sel_next = 1'b1;
                        addr_next = addr_reg + 16'h0001;
                    end
                    else
                    begin
                        svc_addr_next = {data_sync_reg, lo_reg};
                        svc_next = 1'b1;
                        memory_request_strobe_next = 1'b0;
                        state_next = cir_pkg::CIR_IDLE;
                    end
                end
            end
            default:
                state_next = cir_pkg::CIR_IDLE;
        endcase

        // a fresh edge is never lost to a clear in the same cycle
        if (nmi_sync_reg && !nmi_last_reg)
            nmi_pend_next = 1'b1;
        busy_next = ofc_next | memory_request_strobe_next;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= cir_pkg::CIR_IDLE;
            iff1_reg <= `CIR_IFF_RESET;
            iff2_reg <= `CIR_IFF_RESET;
            mode_reg <= `CIR_MODE_RESET;
            page_reg <= `CIR_PAGE_RESET;
            refresh_reg <= `CIR_REFRESH_RESET;
            nmi_pend_reg <= 1'b0;
            ofc_reg <= 1'b0;
            io_reg <= 1'b0;
            memory_request_strobe_reg <= 1'b0;
            addr_reg <= 16'h0000;
            svc_addr_reg <= 16'h0000;
            svc_reg <= 1'b0;
            jam_reg <= 1'b0;
            jam_op_reg <= 8'h00;
            lo_reg <= 8'h00;
            pv_reg <= 1'b0;
            pv_valid_reg <= 1'b0;
            hi_sel_reg <= 1'b0;
            cnt_reg <= 2'h0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            iff1_reg <= iff1_next;
            iff2_reg <= iff2_next;
            mode_reg <= mode_next;
            page_reg <= page_next;
            refresh_reg <= refresh_next;
            nmi_pend_reg <= nmi_pend_next;
            ofc_reg <= ofc_next;
            io_reg <= io_next;
            memory_request_strobe_reg <= memory_request_strobe_next;
            addr_reg <= addr_next;
            svc_addr_reg <= svc_addr_next;
            svc_reg <= svc_next;
            jam_reg <= jam_next;
            jam_op_reg <= jam_op_next;
            lo_reg <= lo_next;
            pv_reg <= pv_next;
            pv_valid_reg <= pv_valid_next;
            hi_sel_reg <= hi_sel_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    assign opcode_fetch_cycle = ofc_reg;
    assign io_request_strobe = io_reg;
    assign memory_request_strobe = memory_request_strobe_reg;
    assign addr_out = addr_reg;
    assign service_valid = svc_reg;
    assign service_addr = svc_addr_reg;
    assign jam_valid = jam_reg;
    assign jam_opcode = jam_op_reg;
    assign int_enable_ff_one = iff1_reg;
    assign int_enable_ff_two = iff2_reg;
    assign int_mode_flops = mode_reg;
    assign vector_page = page_reg;
    assign refresh_count = refresh_reg;
    assign pv_flag = pv_reg;
    assign pv_valid = pv_valid_reg;
    assign ack_busy = busy_reg;

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_nmi_vector: assert property (
        (state_reg == cir_pkg::CIR_IDLE && instr_boundary && !bus_request_in_sync_reg && nmi_pend_reg
        && !disable_int_instr && !enable_int_instr)
        |=> service_valid && service_addr == 16'h0066 && !int_enable_ff_one
        && int_enable_ff_two == $past(int_enable_ff_two))
        else $error("non-maskable accept did not vector to 0066");

    a_int_gated: assert property (
        (state_reg == cir_pkg::CIR_IDLE && (!iff1_reg || bus_request_in_sync_reg))
        |=> state_reg == cir_pkg::CIR_IDLE)
        else $error("maskable request taken while masked or bus requested");

    a_ack_strobes: assert property (
        io_request_strobe |-> opcode_fetch_cycle && !memory_request_strobe)
        else $error("io strobe outside fetch or with memory strobe");

    a_ack_waits: assert property (
        $rose(opcode_fetch_cycle) |-> ##2 io_request_strobe [*3] ##1 !opcode_fetch_cycle)
        else $error("acknowledge cycle not stretched by two waits");

    a_mode1_vector: assert property (
        (state_reg == cir_pkg::CIR_T3 && mode_reg == 2'h1)
        |=> service_valid && service_addr == 16'h0038)
        else $error("mode 1 did not vector to 0038");

    a_table_addr: assert property (
        (state_reg == cir_pkg::CIR_T3 && mode_reg == 2'h2)
        |=> memory_request_strobe && addr_out == {vector_page, $past(data_sync_reg)}
        ##3 addr_out == $past(addr_out, 3) + 16'h0001)
        else $error("mode 2 table pointer wrong");

    a_di_clear: assert property (
        (disable_int_instr && !enable_int_instr) |=> !int_enable_ff_one && !int_enable_ff_two)
        else $error("disable left an enable flip-flop set");

    a_ei_set: assert property (
        (enable_int_instr && !instr_boundary) |=> int_enable_ff_one && int_enable_ff_two)
        else $error("enable did not set both flip-flops");

    a_pv_copy: assert property (
        (read_vector_page || read_refresh)
        |=> pv_valid && pv_flag == $past(int_enable_ff_two))
        else $error("parity flag not loaded from second flip-flop");

    a_refresh_inc: assert property (
        (fetch_refresh && !write_refresh && state_reg == cir_pkg::CIR_IDLE)
        |=> refresh_count == $past(refresh_count) + 8'h01)
        else $error("refresh register did not advance on fetch");

endmodule : cir_unit

// ==== cir_map.svh ====
// Purpose: constants of the interrupt response unit
// Assumes: one clock cycle stands for one processor T state
// Notes: included by cir_unit.sv; cir_pkg.sv does not include it
`ifndef CIR_MAP_SVH
`define CIR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// service addresses
`define CIR_NMI_ADDR 16'h0066
`define CIR_MODE1_ADDR 16'h0038

////////////////////////////////////////////////////////////////////////////////
// opcodes recognised in mode 0
`define CIR_CALL_OPCODE 8'hcd
`define CIR_RST_MASK 8'hc7
`define CIR_RST_MATCH 8'hc7
`define CIR_RST_LSB 3
`define CIR_RST_MSB 5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CIR_IFF_RESET 1'b0
`define CIR_MODE_RESET 2'h0
`define CIR_PAGE_RESET 8'h00
`define CIR_REFRESH_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// timing, in clock cycles
`define CIR_READ_CYCLES 2'h3

`endif

// ==== cir_pkg.sv ====
// Purpose: types of the interrupt response unit
// Assumes: state and mode codes are set here, not taken from cir_map.svh
// Notes: state codes are gray along the acknowledge path
package cir_pkg;

    typedef enum logic [2:0] {
        CIR_IDLE = 3'h0,
        CIR_T1 = 3'h1,
        CIR_T2 = 3'h3,
        CIR_W1 = 3'h2,
        CIR_W2 = 3'h6,
        CIR_T3 = 3'h7,
        CIR_RD = 3'h5
    } cir_state_t;

    typedef enum logic [1:0] {
        CIR_MODE0 = 2'h0,
        CIR_MODE1 = 2'h1,
        CIR_MODE2 = 2'h2
    } cir_mode_t;

endpackage : cir_pkg

// ==== cir_peripheral.sv ====
// Purpose: model of the interrupting peripheral and of memory on the data bus
// Assumes: pins change one nanosecond after the rising clock edge
// Notes: the bus is never left holding a stale value between transfers
`timescale 1ns/1ps

module cir_peripheral (
    input wire logic clock,
    input wire logic rstn,
    input wire logic opcode_fetch_cycle,
    input wire logic io_request_strobe,
    input wire logic memory_request_strobe,
    input wire logic [15:0] addr_out,
    input wire logic [7:0] ack_byte,
    output logic [7:0] data_bus_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5a;
    endfunction : mem_byte

    initial data_bus_pin = 8'h00;

    // idle bus toggles every cycle so a late sample can never match by chance
    always @(posedge clock)
    begin
        #1;
        if (rstn && opcode_fetch_cycle && io_request_strobe)
            data_bus_pin = ack_byte;
        else if (rstn && memory_request_strobe)
            data_bus_pin = mem_byte(addr_out);
        else
            data_bus_pin = ~data_bus_pin;
    end

endmodule : cir_peripheral

// ==== tb_top.sv ====
// Purpose: self-checking bench of the interrupt response unit
// Assumes: inputs change at the falling edge, outputs read there
// Notes: random values from a 16-bit shift register seeded at 63104
`timescale 1ns/1ps

module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic nmi_pin = 1'b0, int_pin = 1'b0, bus_request_in = 1'b0, instr_boundary = 1'b0;
    logic disable_int_instr = 1'b0, enable_int_instr = 1'b0, return_from_nonmask_instr = 1'b0;
    logic set_mode_instr = 1'b0, write_vector_page = 1'b0, write_refresh = 1'b0;
    logic read_vector_page = 1'b0, read_refresh = 1'b0, fetch_refresh = 1'b0;
    logic [1:0] set_mode_value = 2'h0;
    logic [7:0] write_data = 8'h00, ack_byte = 8'h00;
    logic [15:0] pc_in = 16'h0000, seed = 16'hf680;
    logic opcode_fetch_cycle, io_request_strobe, memory_request_strobe, service_valid;
    logic jam_valid, int_enable_ff_one, int_enable_ff_two, pv_flag, pv_valid, ack_busy;
    logic [15:0] addr_out, service_addr;
    logic [7:0] jam_opcode, vector_page, refresh_count, data_bus_pin;
    logic [1:0] int_mode_flops;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    cir_unit DUT (.clock(clock), .rstn(rstn), .nmi_pin(nmi_pin), .int_pin(int_pin),
        .bus_request_in(bus_request_in), .data_bus_pin(data_bus_pin),
        .instr_boundary(instr_boundary), .disable_int_instr(disable_int_instr),
        .enable_int_instr(enable_int_instr), .return_from_nonmask_instr(return_from_nonmask_instr),
        .set_mode_instr(set_mode_instr), .set_mode_value(set_mode_value),
        .write_vector_page(write_vector_page), .write_refresh(write_refresh),
        .write_data(write_data), .read_vector_page(read_vector_page), .read_refresh(read_refresh),
        .fetch_refresh(fetch_refresh), .pc_in(pc_in), .opcode_fetch_cycle(opcode_fetch_cycle),
        .io_request_strobe(io_request_strobe), .memory_request_strobe(memory_request_strobe),
        .addr_out(addr_out), .service_valid(service_valid), .service_addr(service_addr),
        .jam_valid(jam_valid), .jam_opcode(jam_opcode), .int_enable_ff_one(int_enable_ff_one),
        .int_enable_ff_two(int_enable_ff_two), .int_mode_flops(int_mode_flops),
        .vector_page(vector_page), .refresh_count(refresh_count), .pv_flag(pv_flag),
        .pv_valid(pv_valid), .ack_busy(ack_busy));

    cir_peripheral PERIPH (.clock(clock), .rstn(rstn), .opcode_fetch_cycle(opcode_fetch_cycle),
        .io_request_strobe(io_request_strobe), .memory_request_strobe(memory_request_strobe),
        .addr_out(addr_out), .ack_byte(ack_byte), .data_bus_pin(data_bus_pin));

    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [7:0] table_byte(input logic [15:0] a);
        return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5a;
    endfunction : table_byte

    function automatic logic [15:0] exp_service(input logic [1:0] m, input logic [7:0] ack,
        input logic [7:0] page, input logic [15:0] pc);
        logic [15:0] p;
        p = {page, ack};
        if (m == 2'h1)
            return 16'h0038;
        if (m == 2'h2)
            return {table_byte(p + 16'h0001), table_byte(p)};
        if (ack == 8'hcd)
            return {table_byte(pc + 16'h0001), table_byte(pc)};
        return {10'h000, ack[5:3], 3'h0};
    endfunction : exp_service

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // op: 0 disable, 1 enable, 2 return, 3 mode, 4 page, 5 refresh, 6/7 reads, 8 fetch
    task automatic do_op(input int op, input logic [7:0] d);
        @(negedge clock);
        write_data = d;
        set_mode_value = d[1:0];
        {return_from_nonmask_instr, enable_int_instr, disable_int_instr} = 3'(1 << op) & 3'h7;
        {write_refresh, write_vector_page, set_mode_instr} = 3'(1 << op >> 3) & 3'h7;
        {fetch_refresh, read_refresh, read_vector_page} = 3'(1 << op >> 6) & 3'h7;
        @(negedge clock);
        {disable_int_instr, enable_int_instr, return_from_nonmask_instr} = 3'h0;
        {set_mode_instr, write_vector_page, write_refresh} = 3'h0;
        {read_vector_page, read_refresh, fetch_refresh} = 3'h0;
    endtask : do_op

    task automatic boundary;
        instr_boundary = 1'b1;
        @(negedge clock);
        instr_boundary = 1'b0;
    endtask : boundary

    // one maskable acknowledge, counted cycle by cycle at the falling edge
    task automatic run_int(input logic [7:0] ack, input logic [15:0] exp_addr, input logic jam);
        int fetch_n, io_n, memory_request_strobe_bad, waitc;
        logic done;
        logic [7:0] r0;
        ack_byte = ack;
        int_pin = 1'b1;
        repeat (3) @(negedge clock);
        r0 = refresh_count;
        boundary();
        int_pin = 1'b0;
        fetch_n = 0;
        io_n = 0;
        memory_request_strobe_bad = 0;
        done = 1'b0;
        chk_word(addr_out, pc_in);
        for (waitc = 0; waitc < 40 && !done; waitc++)
        begin
            fetch_n += int'(opcode_fetch_cycle);
            io_n += int'(io_request_strobe);
            memory_request_strobe_bad += int'(opcode_fetch_cycle & memory_request_strobe);
            if (service_valid === 1'b1 || jam_valid === 1'b1)
                done = 1'b1;
            else
                @(negedge clock);
        end
        chk_word(16'(fetch_n), 16'h0005);
        chk_word(16'(io_n), 16'h0003);
        chk_word(16'(memory_request_strobe_bad), 16'h0000);
        chk_bit(jam_valid, jam);
        chk_bit(service_valid, !jam);
        chk_word(jam ? {8'h00, jam_opcode} : service_addr, jam ? {8'h00, ack} : exp_addr);
        chk_word({8'h00, refresh_count}, {8'h00, r0 + 8'h01});
        chk_bit(int_enable_ff_one | int_enable_ff_two, 1'b0);
        @(negedge clock);
    endtask : run_int

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        logic [1:0] m;
        logic [7:0] a;
        logic [7:0] pg;
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        chk_word({int_enable_ff_one, int_enable_ff_two, int_mode_flops, refresh_count, vector_page},
            16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            do_op(3, 8'(i));
            chk_word({14'h0, int_mode_flops}, (i < 3) ? 16'(i) : 16'h0002);
        end
        do_op(1, 8'h00);
        chk_word({14'h0, int_enable_ff_one, int_enable_ff_two}, 16'h0003);
        do_op(6, 8'h00);
        chk_word({13'h0, pv_valid, pv_flag, int_enable_ff_one}, 16'h0007);
        do_op(0, 8'h00);
        chk_word({14'h0, int_enable_ff_one, int_enable_ff_two}, 16'h0000);
        do_op(7, 8'h00);
        chk_word({13'h0, pv_valid, pv_flag, int_enable_ff_two}, 16'h0004);
        do_op(5, 8'hfe);
        do_op(8, 8'h00);
        do_op(8, 8'h00);
        chk_word({8'h00, refresh_count}, 16'h0000);
        int_pin = 1'b1;
        repeat (3) @(negedge clock);
        boundary();
        repeat (8) @(negedge clock)
            chk_bit(opcode_fetch_cycle | service_valid, 1'b0);
        int_pin = 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            seed = lfsr_next(seed);
            m = (seed[1:0] == 2'h3) ? 2'h2 : seed[1:0];
            do_op(3, {6'h00, m});
            pg = seed[15:8];
            do_op(4, pg);
            do_op(1, 8'h00);
            seed = lfsr_next(seed);
            pc_in = seed;
            seed = lfsr_next(seed);
            if (m == 2'h2)
                a = {seed[7:1], 1'b0};
            else if (seed[1:0] == 2'h0)
                a = {2'h3, seed[4:2], 3'h7};
            else if (seed[1:0] == 2'h1)
                a = 8'hcd;
            else
                a = {1'b0, seed[10:4]};
            run_int(a, exp_service(m, a, pg, pc_in),
                m == 2'h0 && a[7:6] != 2'h3 && a != 8'hcd);
        end
        do_op(1, 8'h00);
        bus_request_in = 1'b1;
        int_pin = 1'b1;
        nmi_pin = 1'b1;
        repeat (3) @(negedge clock);
        nmi_pin = 1'b0;
        boundary();
        repeat (6) @(negedge clock)
            chk_bit(opcode_fetch_cycle | service_valid, 1'b0);
        bus_request_in = 1'b0;
        repeat (3) @(negedge clock);
        boundary();
        chk_word(service_addr, 16'h0066);
        chk_word({13'h0, service_valid, int_enable_ff_one, int_enable_ff_two}, 16'h0005);
        int_pin = 1'b0;
        do_op(2, 8'h00);
        chk_word({14'h0, int_enable_ff_one, int_enable_ff_two}, 16'h0003);
        results();
    end

endmodule : tb_top
